/* core/tsl_consts.svh */
// Constants for the status-restore and multiplier-operand load engine.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef TSL_CONSTS_SVH
`define TSL_CONSTS_SVH

// Register byte offsets on the Avalon slave.
`define TSL_OFF_INSTR   7'h00
`define TSL_OFF_STAT    7'h04
`define TSL_OFF_TIME    7'h08
`define TSL_OFF_ST0     7'h0c
`define TSL_OFF_ST1     7'h10
`define TSL_OFF_ACC     7'h14
`define TSL_OFF_PRODUCT_REG    7'h18
`define TSL_OFF_MULT_OPERAND_REG    7'h1c
`define TSL_OFF_PC      7'h20
`define TSL_OFF_MADDR   7'h24
`define TSL_OFF_MDATA   7'h28
`define TSL_OFF_AR_BIT  6

// Instruction word fields and opcodes (high byte).
`define TSL_I_OPC       15:8
`define TSL_I_IND       7
`define TSL_I_DMA       6:0
`define TSL_I_ARU       6:4
`define TSL_I_NEN       3
`define TSL_I_NAR       2:0
`define TSL_OPC_LST0    8'h0e
`define TSL_OPC_LST1    8'h0f
`define TSL_OPC_LT      8'h73
`define TSL_OPC_LTA     8'h70

// Indirect update codes.
`define TSL_ARU_DEC     3'h1
`define TSL_ARU_INC     3'h2
`define TSL_ARU_BRDEC   3'h4
`define TSL_ARU_IXDEC   3'h5
`define TSL_ARU_IXINC   3'h6
`define TSL_ARU_BRINC   3'h7

// Status register fields, reserved masks and reset values.
`define TSL_ST_PTR      15:13
`define TSL_ST0_OV      12
`define TSL_ST0_OVM     11
`define TSL_ST0_GLOBAL_IRQ_MASK    9
`define TSL_ST0_DP      8:0
`define TSL_ST1_C       9
`define TSL_ST1_PM      1:0
`define TSL_ST0_RSV     16'h0400
`define TSL_ST1_RSV     16'h01ec
`define TSL_GLOBAL_IRQ_MASK_MASK   16'h0200
`define TSL_ST0_RST     16'h0600
`define TSL_ST1_RST     16'h01fc

// Timing configuration fields and location codes.
`define TSL_TM_D        3:0
`define TSL_TM_P        7:4
`define TSL_TM_OPLOC    9:8
`define TSL_TM_CODELOC  11:10
`define TSL_TM_SAME     12
`define TSL_TM_RPT      23:16
`define TSL_OPLOC_SINGLE_ACCESS_RAM 2'h1
`define TSL_OPLOC_EXT   2'h2
`define TSL_CODE_SINGLE_ACCESS_RAM  2'h2
`define TSL_CODE_EXT    2'h3

// Product shift codes and saturation limits.
`define TSL_PM_L1       2'h1
`define TSL_PM_L4       2'h2
`define TSL_PM_R6       2'h3
`define TSL_SAT_POS     32'h7fffffff
`define TSL_SAT_NEG     32'h80000000

`endif

/* core/tsl_pkg.sv */
// Types shared by the load engine files.
// Assumes nothing of its surroundings.
package tsl_pkg;
  // Engine states, Gray coded along idle, execute, wait.
  typedef enum logic [1:0] {
    TSL_IDLE = 2'b00,
    TSL_EXEC = 2'b01,
    TSL_WAIT = 2'b11
  } tsl_state_t;

  // Decoded instruction kind.
  typedef enum logic [2:0] {
    TSL_OP_NONE = 3'h0,
    TSL_OP_LST0 = 3'h1,
    TSL_OP_LST1 = 3'h2,
    TSL_OP_LT   = 3'h3,
    TSL_OP_LTA  = 3'h4
  } tsl_op_t;
endpackage

/* core/tsl_acc_if.sv */
// Interface between the engine and its accumulate adder.
// Assumes both ends run in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
interface tsl_acc_if;
  logic [1:0]  pm;
  logic        overflow_saturate_mode;
  logic [31:0] acc;
  logic [31:0] product_reg;
  logic [31:0] sum;
  logic        carry;
  logic        ovf;
  modport core (output pm, overflow_saturate_mode, acc, product_reg, input sum, carry, ovf);
  modport alu (input pm, overflow_saturate_mode, acc, product_reg, output sum, carry, ovf);
endinterface
`default_nettype wire

/* core/tsl_acc_add.sv */
// Accumulate adder: shifted product added to the accumulator.
// Assumes purely combinational use by the engine.
`timescale 1ns/100ps
`default_nettype none
`include "tsl_consts.svh"
module tsl_acc_add (
  // Operands and results.
  tsl_acc_if.alu a
);
  logic [31:0] shifted;
  logic [32:0] wide;

  // Shift, add with carry out, then detect signed overflow and saturate.
  always_comb begin
    case (a.pm)
      `TSL_PM_L1: shifted = {a.product_reg[30:0], 1'b0};
      `TSL_PM_L4: shifted = {a.product_reg[27:0], 4'h0};
      `TSL_PM_R6: shifted = {{6{a.product_reg[31]}}, a.product_reg[31:6]};
      default:    shifted = a.product_reg;
    endcase
    wide    = {1'b0, a.acc} + {1'b0, shifted};
    a.carry = wide[32];
    a.ovf   = (a.acc[31] == shifted[31]) && (wide[31] != a.acc[31]);
    // Saturation only under the overflow mode; otherwise the sum wraps.
    if (a.ovf && a.overflow_saturate_mode) begin
      a.sum = a.acc[31] ? `TSL_SAT_NEG : `TSL_SAT_POS;
    end else begin
      a.sum = wide[31:0];
    end
  end
endmodule
`default_nettype wire

/* core/tsl_exec.sv */
// Execution engine for status restore and multiplier-operand loads.
// Assumes an Avalon-MM master on clk and that software fills the data memory.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tsl_consts.svh"
module tsl_exec #(
  parameter int MEM_AW = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM register slave.
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Engine state.
  output logic             exec_busy
);

  // Merge write data into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Mirror a 16-bit word end for end.
  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  // Add or subtract with carries running from the high bit downward.
  function automatic logic [15:0] rev_add(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic        sub);
    logic [15:0] s;
    s = sub ? bit_rev(a) - bit_rev(b) : bit_rev(a) + bit_rev(b);
    return bit_rev(s);
  endfunction

  tsl_pkg::tsl_state_t state_r, state_nxt;
  tsl_pkg::tsl_op_t    op_r, op_nxt, op_dec;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        busy_r, busy_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [31:0] time_r, time_nxt;
  logic [15:0] st0_r, st0_nxt;
  logic [15:0] st1_r, st1_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [31:0] product_reg_r, product_reg_nxt;
  logic [15:0] mult_operand_reg_r, mult_operand_reg_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] ar_r [8];
  logic [15:0] ar_nxt [8];
  logic [MEM_AW-1:0] maddr_r, maddr_nxt;
  logic [8:0]  iter_r, iter_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] cyc_r, cyc_nxt;
  logic [15:0] mem [2**MEM_AW];
  logic        mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  logic        accept, is_stat;
  logic [6:0]  word_a;
  logic [31:0] wr_w;
  logic [2:0]  ptr;
  logic [15:0] eff_addr, opnd, ar_upd;
  logic [8:0]  n9;
  logic [15:0] n16, kn, nd16, tot;
  logic        shared, ext_op, ext_code;

  tsl_acc_if acc_bus ();

  // Accumulate adder fed by the live accumulator and product.
  tsl_acc_add u_add (
    .a (acc_bus.alu)
  );

  assign acc_bus.pm   = st1_r[`TSL_ST1_PM];
  assign acc_bus.overflow_saturate_mode  = st0_r[`TSL_ST0_OVM];
  assign acc_bus.acc  = acc_r;
  assign acc_bus.product_reg = product_reg_r;

  // Outputs come straight from their flops.
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign exec_busy       = busy_r;

  // Next values for the bus slave, the register file and the engine.
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    wait_nxt  = wait_r;
    rdata_nxt = rdata_r;
    busy_nxt  = busy_r;
    instr_nxt = instr_r;
    time_nxt  = time_r;
    st0_nxt   = st0_r;
    st1_nxt   = st1_r;
    acc_nxt   = acc_r;
    product_reg_nxt  = product_reg_r;
    mult_operand_reg_nxt  = mult_operand_reg_r;
    pc_nxt    = pc_r;
    ar_nxt    = ar_r;
    maddr_nxt = maddr_r;
    iter_nxt  = iter_r;
    cnt_nxt   = cnt_r;
    cyc_nxt   = cyc_r;
    mem_we    = 1'b0;
    mem_wa    = maddr_r;
    mem_wd    = 16'h0000;

    // Operand fetch for the instruction in hand; decode of the opcode being written.
    ptr = st0_r[`TSL_ST_PTR];
    if (instr_r[`TSL_I_IND]) begin
      eff_addr = ar_r[ptr];
    end else begin
      eff_addr = {st0_r[`TSL_ST0_DP], instr_r[`TSL_I_DMA]};
    end
    opnd = mem[eff_addr[MEM_AW-1:0]];
    case (instr_r[`TSL_I_ARU])
      `TSL_ARU_DEC:   ar_upd = ar_r[ptr] - 16'h0001;
      `TSL_ARU_INC:   ar_upd = ar_r[ptr] + 16'h0001;
      `TSL_ARU_BRDEC: ar_upd = rev_add(ar_r[ptr], ar_r[0], 1'b1);
      `TSL_ARU_IXDEC: ar_upd = ar_r[ptr] - ar_r[0];
      `TSL_ARU_IXINC: ar_upd = ar_r[ptr] + ar_r[0];
      `TSL_ARU_BRINC: ar_upd = rev_add(ar_r[ptr], ar_r[0], 1'b0);
      default:        ar_upd = ar_r[ptr];
    endcase
    case (instr_nxt_src(avs_writedata[15:0]))
      `TSL_OPC_LST0: op_dec = tsl_pkg::TSL_OP_LST0;
      `TSL_OPC_LST1: op_dec = tsl_pkg::TSL_OP_LST1;
      `TSL_OPC_LT:   op_dec = tsl_pkg::TSL_OP_LT;
      `TSL_OPC_LTA:  op_dec = tsl_pkg::TSL_OP_LTA;
      default:       op_dec = tsl_pkg::TSL_OP_NONE;
    endcase

    // Cycle budget: base per pass, shared block, external data and code.
    n9       = {1'b0, time_r[`TSL_TM_RPT]} + 9'h001;
    n16      = {7'h00, n9};
    ext_op   = time_r[`TSL_TM_OPLOC] == `TSL_OPLOC_EXT;
    ext_code = time_r[`TSL_TM_CODELOC] == `TSL_CODE_EXT;
    shared   = (time_r[`TSL_TM_OPLOC] == `TSL_OPLOC_SINGLE_ACCESS_RAM) &&
               (time_r[`TSL_TM_CODELOC] == `TSL_CODE_SINGLE_ACCESS_RAM) && time_r[`TSL_TM_SAME];
    kn       = (op_dec == tsl_pkg::TSL_OP_LST0 || op_dec == tsl_pkg::TSL_OP_LST1) ?
               {n16[14:0], 1'b0} : n16;
    nd16     = n16 * {12'h000, time_r[`TSL_TM_D]};
    tot      = kn + {15'h0000, shared} + (ext_op ? nd16 : 16'h0000) +
               (ext_code ? {12'h000, time_r[`TSL_TM_P]} : 16'h0000) +
               {15'h0000, ext_op && ext_code};

    // Bus slave: take a request, answer one cycle later, act on completion.
    word_a  = {avs_address[6:2], 2'b00};
    is_stat = word_a == `TSL_OFF_STAT;
    accept  = (avs_read || avs_write) && wait_r && !(busy_r && !is_stat);
    if (accept) begin
      wait_nxt = 1'b0;
      if (avs_address[`TSL_OFF_AR_BIT]) begin
        rdata_nxt = {16'h0000, ar_r[avs_address[4:2]]};
      end else begin
        case (word_a)
          `TSL_OFF_INSTR: rdata_nxt = {16'h0000, instr_r};
          `TSL_OFF_STAT:  rdata_nxt = {cyc_r, 15'h0000, busy_r};
          `TSL_OFF_TIME:  rdata_nxt = time_r;
          `TSL_OFF_ST0:   rdata_nxt = {16'h0000, st0_r | `TSL_ST0_RSV};
          `TSL_OFF_ST1:   rdata_nxt = {16'h0000, st1_r | `TSL_ST1_RSV};
          `TSL_OFF_ACC:   rdata_nxt = acc_r;
          `TSL_OFF_PRODUCT_REG:  rdata_nxt = product_reg_r;
          `TSL_OFF_MULT_OPERAND_REG:  rdata_nxt = {16'h0000, mult_operand_reg_r};
          `TSL_OFF_PC:    rdata_nxt = {16'h0000, pc_r};
          `TSL_OFF_MADDR: rdata_nxt = {{(32-MEM_AW){1'b0}}, maddr_r};
          `TSL_OFF_MDATA: rdata_nxt = {16'h0000, mem[maddr_r]};
          default:        rdata_nxt = 32'h00000000;
        endcase
      end
    end else if (!wait_r) begin
      wait_nxt = 1'b1;
    end

    // Writes land at the edge where the master sees waitrequest low.
    if (!wait_r && avs_write) begin
      wr_w = be_merge({16'h0000, instr_r}, avs_writedata, avs_byteenable);
      if (avs_address[`TSL_OFF_AR_BIT]) begin
        ar_nxt[avs_address[4:2]] = 16'(be_merge({16'h0000, ar_r[avs_address[4:2]]},
                                                avs_writedata, avs_byteenable));
      end else begin
        case (word_a)
          `TSL_OFF_INSTR: begin
            instr_nxt = wr_w[15:0];
            op_nxt    = op_dec;
            if (op_dec != tsl_pkg::TSL_OP_NONE) begin
              pc_nxt    = pc_r + 16'h0001;
              busy_nxt  = 1'b1;
              state_nxt = tsl_pkg::TSL_EXEC;
              iter_nxt  = n9;
              cnt_nxt   = tot;
              cyc_nxt   = tot;
            end
          end
          `TSL_OFF_TIME:  time_nxt = be_merge(time_r, avs_writedata, avs_byteenable);
          `TSL_OFF_ST0:   st0_nxt = 16'(be_merge({16'h0000, st0_r}, avs_writedata,
                                                 avs_byteenable)) | `TSL_ST0_RSV;
          `TSL_OFF_ST1:   st1_nxt = 16'(be_merge({16'h0000, st1_r}, avs_writedata,
                                                 avs_byteenable)) | `TSL_ST1_RSV;
          `TSL_OFF_ACC:   acc_nxt = be_merge(acc_r, avs_writedata, avs_byteenable);
          `TSL_OFF_PRODUCT_REG:  product_reg_nxt = be_merge(product_reg_r, avs_writedata, avs_byteenable);
          `TSL_OFF_MULT_OPERAND_REG:  mult_operand_reg_nxt = 16'(be_merge({16'h0000, mult_operand_reg_r}, avs_writedata,
                                                  avs_byteenable));
          `TSL_OFF_PC:    pc_nxt = 16'(be_merge({16'h0000, pc_r}, avs_writedata,
                                                avs_byteenable));
          `TSL_OFF_MADDR: maddr_nxt = avs_writedata[MEM_AW-1:0];
          `TSL_OFF_MDATA: begin
            mem_we = 1'b1;
            mem_wd = 16'(be_merge({16'h0000, mem[maddr_r]}, avs_writedata,
                                  avs_byteenable));
          end
          default: ;
        endcase
      end
    end else begin
      wr_w = 32'h00000000;
    end

    // Engine: one pass per cycle while passes remain, then idle out the budget.
    case (state_r)
      tsl_pkg::TSL_EXEC: begin
        // The addressed register moves first, then the pointer is replaced.
        if (instr_r[`TSL_I_IND]) begin
          ar_nxt[ptr] = ar_upd;
        end
        case (op_r)
          tsl_pkg::TSL_OP_LST0: begin
            // Interrupt mask kept; pointer from the word; buffer left alone.
            st0_nxt = (opnd & ~`TSL_GLOBAL_IRQ_MASK_MASK) | (st0_r & `TSL_GLOBAL_IRQ_MASK_MASK)
                      | `TSL_ST0_RSV;
          end
          tsl_pkg::TSL_OP_LST1: begin
            st1_nxt = opnd | `TSL_ST1_RSV;
            st0_nxt[`TSL_ST_PTR] = opnd[`TSL_ST_PTR];
          end
          tsl_pkg::TSL_OP_LT: begin
            mult_operand_reg_nxt = opnd;
          end
          tsl_pkg::TSL_OP_LTA: begin
            mult_operand_reg_nxt = opnd;
            acc_nxt  = acc_bus.sum;
            st1_nxt[`TSL_ST1_C] = acc_bus.carry;
            // Overflow is sticky: an overflow sets it, nothing here clears it.
            st0_nxt[`TSL_ST0_OV] = st0_r[`TSL_ST0_OV] | acc_bus.ovf;
          end
          default: ;
        endcase
        if (instr_r[`TSL_I_IND] && instr_r[`TSL_I_NEN] &&
            (op_r == tsl_pkg::TSL_OP_LT || op_r == tsl_pkg::TSL_OP_LTA)) begin
          st0_nxt[`TSL_ST_PTR] = instr_r[`TSL_I_NAR];
        end
        iter_nxt = iter_r - 9'h001;
        cnt_nxt  = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          state_nxt = tsl_pkg::TSL_IDLE;
          busy_nxt  = 1'b0;
        end else if (iter_r == 9'h001) begin
          state_nxt = tsl_pkg::TSL_WAIT;
        end
      end
      tsl_pkg::TSL_WAIT: begin
        // Wait states and memory conflicts hold the engine busy.
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          state_nxt = tsl_pkg::TSL_IDLE;
          busy_nxt  = 1'b0;
        end
      end
      default: ;
    endcase
  end

  // Incoming opcode byte used by the decoder when an instruction is written.
  function automatic logic [7:0] instr_nxt_src(input logic [15:0] w);
    return w[`TSL_I_OPC];
  endfunction

  // Registers only; the data memory carries no reset.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (reset) begin
      state_r <= tsl_pkg::TSL_IDLE;
      op_r    <= tsl_pkg::TSL_OP_NONE;
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
      busy_r  <= 1'b0;
      instr_r <= 16'h0000;
      time_r  <= 32'h00000000;
      st0_r   <= `TSL_ST0_RST;
      st1_r   <= `TSL_ST1_RST;
      acc_r   <= 32'h00000000;
      product_reg_r  <= 32'h00000000;
      mult_operand_reg_r  <= 16'h0000;
      pc_r    <= 16'h0000;
      maddr_r <= '0;
      iter_r  <= 9'h000;
      cnt_r   <= 16'h0000;
      cyc_r   <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        ar_r[i] <= 16'h0000;
      end
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      busy_r  <= busy_nxt;
      instr_r <= instr_nxt;
      time_r  <= time_nxt;
      st0_r   <= st0_nxt;
      st1_r   <= st1_nxt;
      acc_r   <= acc_nxt;
      product_reg_r  <= product_reg_nxt;
      mult_operand_reg_r  <= mult_operand_reg_nxt;
      pc_r    <= pc_nxt;
      maddr_r <= maddr_nxt;
      iter_r  <= iter_nxt;
      cnt_r   <= cnt_nxt;
      cyc_r   <= cyc_nxt;
      for (int i = 0; i < 8; i++) begin
        ar_r[i] <= ar_nxt[i];
      end
    end
  end

endmodule
`default_nettype wire

/* bench/tsl_mem_model.sv */
// Shadow of the data memory words that software placed.
// Assumes the bench records every memory word it writes.
`timescale 1ns/100ps
`default_nettype none
module tsl_mem_model;
  logic [15:0] mem [256];
  // Loads never write memory, so a word stays as it was put.
  task automatic put(input logic [7:0] a, input logic [15:0] w);
    mem[a] = w;
  endtask
endmodule
`default_nettype wire

/* bench/tsl_chk.sv */
// Checker for the register bus handshake and the busy budget.
// Assumes binding to tsl_exec and full byte enables on writes.
`timescale 1ns/100ps
`default_nettype none
module tsl_chk #(
  parameter int MEM_AW = 8
) (
  // Watched ports.
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        exec_busy
);
  logic [31:0] cfg_r;
  logic [1:0]  k_r;
  logic [15:0] cnt_r;
  int          t_exp;
  wire logic   wr_done = avs_write && !avs_waitrequest;
  wire logic   rd_done = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Track timing setup, instruction kind and the busy run length.
  always_ff @(posedge clk) begin
    if (reset) cfg_r <= 32'h0;
    else if (wr_done && avs_address[6:2] == 5'h02) cfg_r <= avs_writedata;
    if (wr_done && avs_address[6:2] == 5'h00) k_r <= avs_writedata[15:9] == 7'h07 ? 2'h2 : 2'h1;
    cnt_r <= exec_busy ? cnt_r + 16'h1 : 16'h0;
  end
  // Budget from the last setup; the shared-block bit is trusted as written.
  always_comb begin
    t_exp = k_r * (cfg_r[23:16] + 1) +
            (cfg_r[12] && cfg_r[9:8] == 2'h1 && cfg_r[11:10] == 2'h2);
    if (cfg_r[9:8] == 2'h2) t_exp += (cfg_r[23:16] + 1) * cfg_r[3:0];
    if (cfg_r[11:10] == 2'h3) t_exp += cfg_r[7:4] + (cfg_r[9:8] == 2'h2);
  end
  sequence s_take_idle;
    $rose(avs_read) && !exec_busy;
  endsequence
  sequence s_start;
    wr_done && avs_address[6:2] == 5'h00 && avs_writedata[15:8] inside {8'h0e, 8'h0f, 8'h70, 8'h73};
  endsequence
  a_wait_one_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_reset_idle: assert property (disable iff (1'b0)
    reset |=> avs_waitrequest && !exec_busy && avs_readdata == 32'h0)
    else $error("outputs not idle after reset");
  a_idle_answer: assert property (s_take_idle |=> !avs_waitrequest)
    else $error("idle read not answered on the next edge");
  a_busy_holds: assert property (exec_busy && (avs_read || avs_write) &&
    avs_address[6:2] != 5'h01 |-> avs_waitrequest)
    else $error("access answered while busy");
  a_busy_start: assert property (s_start |=> exec_busy)
    else $error("busy not raised by an instruction");
  a_cycle_count: assert property ($fell(exec_busy) |-> cnt_r == t_exp[15:0])
    else $error("busy length differs from budget");
  a_rdata_holds: assert property (rd_done |=> $stable(avs_readdata))
    else $error("read data moved after the access");
  a_st0_reserved: assert property (rd_done && avs_address[6:2] == 5'h03 |->
    (avs_readdata & 32'hffff0400) == 32'h0400)
    else $error("status zero reserved bits wrong");
  a_st1_reserved: assert property (rd_done && avs_address[6:2] == 5'h04 |->
    (avs_readdata & 32'hffff01ec) == 32'h01ec)
    else $error("status one reserved bits wrong");
endmodule
bind tsl_exec tsl_chk #(.MEM_AW(MEM_AW)) u_chk (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy));
`default_nettype wire

/* bench/mult_operand_reg_status_load_exec_bench.sv */
// Self-checking bench for the load engine through its register bus.
// Assumes MEM_AW of 8 and full byte enables on every write.
`timescale 1ns/100ps
`default_nettype none
`include "tsl_consts.svh"
module mult_operand_reg_status_load_exec_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [6:0]  adr = 7'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic        busy;
  logic [31:0] seed = 32'h2ce71850;
  int          n_errors = 0;
  int          total_checks = 0;
  tsl_exec #(.MEM_AW(8)) dut (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .exec_busy(busy));
  tsl_mem_model u_mem ();
  // Clock at 100 MHz.
  initial forever #5 clk = ~clk;
  // Xorshift source with a fixed start so runs repeat.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Busy length for one instruction under a timing setup.
  function automatic logic [31:0] t_exp(input logic [1:0] op, input logic [31:0] c);
    int n;
    n = c[23:16] + 1;
    t_exp = (op < 2 ? 2 : 1) * n + (c[12] && c[9:8] == 2'h1 && c[11:10] == 2'h2) +
            (c[9:8] == 2'h2 ? n * c[3:0] : 0);
    if (c[11:10] == 2'h3) t_exp += c[7:4] + (c[9:8] == 2'h2);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access; the request holds until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wreq !== 1'b0 && i < 1000);
    if (wreq !== 1'b0) begin
      n_errors++;
      end_of_test();
    end else begin
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task automatic wrr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [6:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // Random instructions with overflow, shared-block and external corners.
  initial begin
    logic [31:0] q, b, acc, pr, acce, cfg;
    logic [32:0] sm;
    logic [15:0] w, s0, s1, s0e, s1e, ar, tre;
    logic [7:0]  ma;
    logic [6:0]  dma;
    logic [2:0]  aux_reg_pointer, next_aux_reg_field;
    logic [1:0]  op;
    logic        ind, nen, ovf;
    int          pce, n;
    logic [7:0]  opcs [4];
    opcs = '{`TSL_OPC_LST0, `TSL_OPC_LST1, `TSL_OPC_LT, `TSL_OPC_LTA};
    for (int i = 0; i < 24; i++) begin
      if (i % 12 == 0) begin
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        pce = 0;
        tre = 16'h0;
        rdc("st0 reset", `TSL_OFF_ST0, 32'h0600);
        rdc("st1 reset", `TSL_OFF_ST1, 32'h01fc);
        rdc("unmapped", 7'h30, 32'h0);
      end
      op = i[1:0];
      {s0, s1} = rnd();
      {w, ar} = rnd();
      acc = rnd();
      pr = rnd();
      b = rnd();
      cfg = rnd();
      {dma, next_aux_reg_field, nen, ind} = b[11:0];
      cfg[31:18] = 14'h0;
      cfg[12] = 1'b0;
      if (cfg[9:8] == 2'h3) cfg[9:8] = 2'h1;
      if (i % 12 >= 4 && i % 12 < 8) cfg[12:8] = 5'h19;
      if (i % 12 >= 8) cfg[11:8] = 4'he;
      if (ind) cfg[17:16] = 2'h0;
      if (op == 2'h3 && i < 8) begin
        acc = 32'h7fffffff;
        pr = 32'h1;
        s1[1:0] = 2'h0;
        s0[11] = (i == 3);
      end
      aux_reg_pointer = s0[15:13];
      // A repeated restore to status zero reloads the page bit; keep it so passes hit one word.
      if (op == 2'h0) w[0] = s0[0];
      ma = ind ? ar[7:0] : {s0[0], dma};
      u_mem.put(ma, w);
      wrr(`TSL_OFF_ST0, {16'h0, s0});
      wrr(`TSL_OFF_ST1, {16'h0, s1});
      wrr(`TSL_OFF_ACC, acc);
      wrr(`TSL_OFF_PRODUCT_REG, pr);
      wrr({2'b10, aux_reg_pointer, 2'h0}, {16'h0, ar});
      wrr(`TSL_OFF_TIME, cfg);
      wrr(`TSL_OFF_MADDR, {24'h0, ma});
      wrr(`TSL_OFF_MDATA, {16'h0, w});
      n = cfg[23:16] + 1;
      s0e = s0 | 16'h0400;
      s1e = s1 | 16'h01ec;
      acce = acc;
      pce++;
      case (op)
        2'h0: s0e = (w & 16'hfdff) | (s0 & 16'h0200) | 16'h0400;
        2'h1: begin
          s1e = w | 16'h01ec;
          s0e[15:13] = w[15:13];
        end
        default: tre = w;
      endcase
      case (s1[1:0])
        2'h0: b = pr;
        2'h1: b = pr << 1;
        2'h2: b = pr << 4;
        default: b = $signed(pr) >>> 6;
      endcase
      for (int k = 0; k < n && op == 2'h3; k++) begin
        sm = {1'b0, acce} + {1'b0, b};
        ovf = acce[31] == b[31] && sm[31] != acce[31];
        s1e[9] = sm[32];
        s0e[12] = s0e[12] | ovf;
        acce = ovf && s0[11] ? {acce[31], {31{!acce[31]}}} : sm[31:0];
      end
      if (ind && nen && op[1]) s0e[15:13] = next_aux_reg_field;
      wrr(`TSL_OFF_INSTR, {16'h0, opcs[op], ind, ind ? {`TSL_ARU_INC, nen, next_aux_reg_field} : dma});
      rdc("st0", `TSL_OFF_ST0, {16'h0, s0e});
      bus(1'b0, `TSL_OFF_STAT, 32'h0, q);
      chk("cycles", {16'h0, q[31:16]}, t_exp(op, cfg));
      rdc("st1", `TSL_OFF_ST1, {16'h0, s1e});
      rdc("acc", `TSL_OFF_ACC, acce);
      rdc("mult_operand_reg", `TSL_OFF_MULT_OPERAND_REG, {16'h0, tre});
      rdc("pc", `TSL_OFF_PC, pce);
      rdc("aux", {2'b10, aux_reg_pointer, 2'h0}, {16'h0, ar + 16'(ind)});
      rdc("mem", `TSL_OFF_MDATA, {16'h0, u_mem.mem[ma]});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
